// file: host_port_pkg.sv
// Package for the floppy controller host port: constants and carrier structs.
// Assumes a single 25 MHz clock domain and synchronous active-low reset.
package host_port_pkg;

  // ************************************************
  // Register map
  // ************************************************
  localparam logic [2:0] ADDR_DATA_BUF  = 3'h5;
  localparam int         DATA_W         = 8;
  localparam logic [7:0] BUS_RESET_VAL  = 8'h00;

  // ************************************************
  // Timing
  // ************************************************
  localparam int CLK_MHZ          = 25;
  localparam int PRIMARY_CLK_MHZ  = 16;
  localparam int SYNC_STAGES      = 2;

  // Host strobes after synchronisation, all active high.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       ack;
    logic       term;
  } strobe_t;

  // Write event toward the core.
  typedef struct packed {
    logic       valid;
    logic [2:0] addr;
    logic [7:0] data;
  } wr_evt_t;

  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_READ  = 2'b01,
    ACC_WRITE = 2'b10
  } acc_state_t;

endpackage : host_port_pkg

// file: fdc_host_dma_interface.sv
// Host bus and DMA handshake port of a floppy disk controller.
// Assumes asynchronous host strobes; tri-state wires are resolved by the testbench.
// Operation
// - Drive read data only while chip select and read strobe both active.
// - On chip-selected write strobe, latch bus byte into addressed register.
// - Host uses chip select; strobes without chip select are ignored.
// - Eight-bit bidirectional data bus, three register select lines.
// - DMA request per byte; first mode tri-states it unless gate bit set.
// - Interrupt on command completion, and per byte in non-DMA operation.
// - Second mode interrupt active low open drain.
// - DMA acknowledge acts as chip select with address five.
// - First mode gates acknowledge with gate bit; second mode does not.
// - Terminal count accepted only with acknowledge (and gate in first mode).
// - Second mode terminal count is active low.
// - Internal timing derived from one clock; no non-standard rates.
// - Static mode select picks first or second application mode.
// - Reset idles the sequencer and makes all outputs inactive.
`timescale 1ns/1ps
module fdc_host_dma_interface #(
  parameter int SYNC_DEPTH = host_port_pkg::SYNC_STAGES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Host bus
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [2:0]  register_select,
  input  wire logic [7:0]  host_data_bus_in,
  output logic      [7:0]  host_data_bus_out,
  output logic             host_data_bus_oe,
  // DMA handshake
  output logic             dma_req_out,
  output logic             dma_req_oe,
  input  wire logic        dma_acknowledge_n,
  input  wire logic        terminal_count,
  // Interrupt pin
  output logic             irq_out,
  output logic             irq_oe,
  // Mode and core side
  input  wire logic        application_mode_select,
  input  wire logic        dma_gate_bit,
  input  wire logic        non_dma_mode,
  input  wire logic        core_xfer_req,
  input  wire logic        core_cmd_done,
  input  wire logic [7:0]  core_rd_data,
  output logic [2:0]       core_rd_addr,
  output host_port_pkg::wr_evt_t core_wr,
  output logic             core_rd_strobe,
  output logic             core_term_count
);

  // ************************************************
  // Input synchronisers
  // ************************************************
  // A single stage cannot keep a strobe edge from being seen twice.
  generate
    if (SYNC_DEPTH < 2) begin : g_bad_depth
      $error("SYNC_DEPTH below two is not supported");
    end
  endgenerate

  host_port_pkg::strobe_t raw_s;
  host_port_pkg::strobe_t sync_ff [SYNC_DEPTH];
  host_port_pkg::strobe_t nxt_sync [SYNC_DEPTH];
  host_port_pkg::strobe_t st;
  logic                   gate_int;
  logic                   ack_q;

  // Mode 1 is the later-desktop mode; gate forced true there.
  assign gate_int = application_mode_select | dma_gate_bit;
  assign ack_q    = ~dma_acknowledge_n & gate_int;

  always_comb begin
    raw_s.rd   = ~rd_n & (~cs_n | ack_q);
    raw_s.wr   = ~wr_n & (~cs_n | ack_q);
    raw_s.ack  = ack_q;
    raw_s.term = application_mode_select ? ~terminal_count : terminal_count;
  end

  genvar g;
  generate
    for (g = 0; g < SYNC_DEPTH; g++) begin : g_sync
      if (g == 0) begin : g_first
        assign nxt_sync[g] = raw_s;
      end else begin : g_rest
        assign nxt_sync[g] = sync_ff[g-1];
      end
      always_ff @(posedge clk) begin
        if (!rst_n) sync_ff[g] <= '0;
        else        sync_ff[g] <= nxt_sync[g];
      end
    end
  endgenerate

  assign st = sync_ff[SYNC_DEPTH-1];

  // ************************************************
  // Access sequencer
  // ************************************************
  host_port_pkg::acc_state_t state_ff, nxt_state;
  logic [7:0]              dout_ff, nxt_dout;
  logic                    oe_ff, nxt_oe;
  logic [2:0]              addr_ff, nxt_addr;
  host_port_pkg::wr_evt_t  wr_ff, nxt_wr;
  logic                    rds_ff, nxt_rds;
  logic                    term_ff, nxt_term;
  logic                    rd_act;

  // Address is only held by the pins during the strobe; acknowledge forces it.
  always_comb begin
    nxt_addr = raw_s.ack ? host_port_pkg::ADDR_DATA_BUF : register_select;
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_dout  = dout_ff;
    nxt_wr    = '0;
    nxt_rds   = 1'b0;
    rd_act    = raw_s.rd & st.rd;
    unique case (state_ff)
      host_port_pkg::ACC_IDLE: begin
        if (st.rd) begin
          nxt_state = host_port_pkg::ACC_READ;
          nxt_rds   = 1'b1;
          nxt_dout  = core_rd_data;
        end else if (st.wr) begin
          nxt_state    = host_port_pkg::ACC_WRITE;
          nxt_wr.valid = 1'b1;
          nxt_wr.addr  = addr_ff;
          nxt_wr.data  = host_data_bus_in;
        end
      end
      host_port_pkg::ACC_READ: begin
        nxt_dout = core_rd_data;
        if (!st.rd) nxt_state = host_port_pkg::ACC_IDLE;
      end
      host_port_pkg::ACC_WRITE: begin
        if (!st.wr) nxt_state = host_port_pkg::ACC_IDLE;
      end
      default: nxt_state = host_port_pkg::ACC_IDLE;
    endcase
    // Drive only while the raw strobe still holds, so the bus is freed one cycle later.
    nxt_oe   = rd_act;
    nxt_term = st.term & st.ack;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= host_port_pkg::ACC_IDLE;
      dout_ff  <= host_port_pkg::BUS_RESET_VAL;
      oe_ff    <= 1'b0;
      addr_ff  <= '0;
      wr_ff    <= '0;
      rds_ff   <= 1'b0;
      term_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      dout_ff  <= nxt_dout;
      oe_ff    <= nxt_oe;
      addr_ff  <= nxt_addr;
      wr_ff    <= nxt_wr;
      rds_ff   <= nxt_rds;
      term_ff  <= nxt_term;
    end
  end

  // ************************************************
  // DMA request and interrupt pins
  // ************************************************
  logic req_ff, nxt_req, req_oe_ff, nxt_req_oe;
  logic irq_o_ff, nxt_irq_o, irq_oe_ff, nxt_irq_oe;
  logic irq_evt;

  always_comb begin
    irq_evt    = core_cmd_done | (non_dma_mode & core_xfer_req);
    nxt_req    = core_xfer_req & ~non_dma_mode & gate_int;
    nxt_req_oe = gate_int;
    if (application_mode_select) begin
      nxt_irq_o  = 1'b0;
      nxt_irq_oe = irq_evt;
    end else begin
      nxt_irq_o  = irq_evt;
      nxt_irq_oe = dma_gate_bit;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_ff    <= 1'b0;
      req_oe_ff <= 1'b0;
      irq_o_ff  <= 1'b0;
      irq_oe_ff <= 1'b0;
    end else begin
      req_ff    <= nxt_req;
      req_oe_ff <= nxt_req_oe;
      irq_o_ff  <= nxt_irq_o;
      irq_oe_ff <= nxt_irq_oe;
    end
  end

  assign host_data_bus_out = dout_ff;
  assign host_data_bus_oe  = oe_ff;
  assign dma_req_out       = req_ff;
  assign dma_req_oe        = req_oe_ff;
  assign irq_out           = irq_o_ff;
  assign irq_oe            = irq_oe_ff;
  assign core_rd_addr      = addr_ff;
  assign core_wr           = wr_ff;
  assign core_rd_strobe    = rds_ff;
  assign core_term_count   = term_ff;

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_wr_start;
    state_ff == host_port_pkg::ACC_IDLE && !st.rd && st.wr;
  endsequence

  chk_bus_drive_gated: assert property (oe_ff |-> $past(!rd_n && (!cs_n || ack_q)))
    else $error("data bus driven without read strobe");
  chk_write_latch: assert property (s_wr_start |=> wr_ff.valid)
    else $error("write not latched");
  chk_write_once: assert property (wr_ff.valid |=> !wr_ff.valid)
    else $error("write event repeated");
  chk_no_cs_ignored: assert property ((cs_n && dma_acknowledge_n) [*4] |=> !st.wr)
    else $error("strobe honoured without chip select");
  chk_ack_addr: assert property (ack_q |=> addr_ff == host_port_pkg::ADDR_DATA_BUF)
    else $error("acknowledge did not select data address");
  chk_req_gate: assert property (!application_mode_select && !dma_gate_bit
                                 |=> !req_oe_ff && !irq_oe_ff)
    else $error("first-mode pins not tri-stated");
  chk_irq_low_od: assert property (application_mode_select [*2] |-> !irq_out)
    else $error("second-mode interrupt drives high");
  chk_term_qual: assert property (core_term_count |-> $past(ack_q, SYNC_DEPTH + 1))
    else $error("terminal count without acknowledge");
  chk_irq_done: assert property (!application_mode_select && dma_gate_bit
                                 && core_cmd_done |=> irq_out && irq_oe)
    else $error("completion interrupt missing");

endmodule : fdc_host_dma_interface

// file: host_bus_model.sv
// Far-side model of the host bus: resolves the shared data bus and the interrupt pin.
// Assumes one clock; the interrupt line carries an external pull-up resistor.
`timescale 1ns/1ps
module host_bus_model (
  // Clock
  input  wire logic       clk,
  // Data bus parties
  input  wire logic [7:0] dev_d,
  input  wire logic       dev_oe,
  input  wire logic [7:0] host_d,
  input  wire logic       host_oe,
  output logic      [7:0] bus,
  // Interrupt pin
  input  wire logic       irq_d,
  input  wire logic       irq_oe,
  output logic            irq_pin
);
  logic [7:0] last_ff;
  // A released bus shows the inverse of its last value, so stale data never passes.
  always_ff @(posedge clk) begin
    if (dev_oe || host_oe) last_ff <= bus;
  end
  assign bus     = dev_oe ? dev_d : (host_oe ? host_d : ~last_ff);
  assign irq_pin = irq_oe ? irq_d : 1'b1;
endmodule : host_bus_model

// file: tb_top.sv
// Self-checking bench for the host bus and DMA port.
// Assumes the package is compiled first; the far side is host_bus_model.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
  typedef struct packed {
    logic m, g, cs, dk, w;
    logic [2:0] a;
    logic [7:0] d;
    logic act;
    logic [2:0] ea;
  } row_t;
  logic clk = 0, rst_n = 0, cs_n = 1, rd_n = 1, wr_n = 1, host_oe = 0;
  logic [2:0] register_select = 3'h0, core_rd_addr;
  logic [7:0] host_data_bus_in, host_data_bus_out, host_d = 8'h00, core_rd_data;
  logic host_data_bus_oe, dma_req_out, dma_req_oe, irq_out, irq_oe, irq_pin;
  logic dma_acknowledge_n = 1, terminal_count = 0, application_mode_select = 0;
  logic dma_gate_bit = 0, non_dma_mode = 0, core_xfer_req = 0, core_cmd_done = 0;
  logic core_rd_strobe, core_term_count;
  host_port_pkg::wr_evt_t core_wr;
  int fails = 0, total_checks = 0;
  row_t rows[7];
  initial forever #20 clk = ~clk;
  assign core_rd_data = {5'h1A, core_rd_addr};
  fdc_host_dma_interface uut (.clk, .rst_n, .cs_n, .rd_n, .wr_n, .register_select,
    .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe, .dma_req_out, .dma_req_oe,
    .dma_acknowledge_n, .terminal_count, .irq_out, .irq_oe, .application_mode_select,
    .dma_gate_bit, .non_dma_mode, .core_xfer_req, .core_cmd_done, .core_rd_data,
    .core_rd_addr, .core_wr, .core_rd_strobe, .core_term_count);
  host_bus_model far (.clk, .dev_d(host_data_bus_out), .dev_oe(host_data_bus_oe),
    .host_d, .host_oe, .bus(host_data_bus_in), .irq_d(irq_out), .irq_oe, .irq_pin);
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // One strobe per access; the strobe is held until the access is seen (one cycle longer for a read) or eight cycles pass.
  task automatic access(input row_t r);
    int hit;
    hit = 0;
    application_mode_select = r.m; dma_gate_bit = r.g; register_select = r.a;
    host_d = r.d; host_oe = r.w; cs_n = ~r.cs; dma_acknowledge_n = ~r.dk;
    wr_n = ~r.w; rd_n = r.w;
    for (int n = 0; n < 8 && hit == 0; n++) begin
      @(posedge clk) #1;
      if (core_wr.valid === 1'b1 || core_rd_strobe === 1'b1) hit = 1;
    end
    `CHK("hit", r.act, hit[0])
    if (hit == 0) `CHK("no_drive", 1'b0, host_data_bus_oe)
    if (hit == 1 && r.w) begin
      `CHK("wr_addr", r.ea, core_wr.addr)
      `CHK("wr_data", r.d, core_wr.data)
    end
    if (hit == 1 && !r.w) begin
      @(posedge clk) #1;
      `CHK("rd_addr", r.ea, core_rd_addr)
      `CHK("rd_bus", {5'h1A, r.ea}, host_data_bus_in)
      `CHK("one_pulse", 1'b0, core_rd_strobe)
    end
    cs_n = 1; dma_acknowledge_n = 1; wr_n = 1; rd_n = 1; host_oe = 0;
    repeat (3) @(posedge clk);
    #1 `CHK("bus_oe", 1'b0, host_data_bus_oe)
  endtask : access
  // Fields: mode, gate, acknowledge pin, terminal count, non-DMA, transfer request, command done.
  task automatic lv(input logic [6:0] v);
    {application_mode_select, dma_gate_bit, dma_acknowledge_n, terminal_count,
      non_dma_mode, core_xfer_req, core_cmd_done} = v;
    repeat (5) @(posedge clk);
    #1;
  endtask : lv
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    wrap_up();
  end
  initial begin
    rows[0] = {5'b01101, 3'h2, 8'hA5, 1'b1, 3'h2};
    rows[1] = {5'b01100, 3'h3, 8'h00, 1'b1, 3'h3};
    rows[2] = {5'b00011, 3'h0, 8'h3C, 1'b0, 3'h5};
    rows[3] = {5'b01011, 3'h0, 8'h5A, 1'b1, 3'h5};
    rows[4] = {5'b10010, 3'h1, 8'h00, 1'b1, 3'h5};
    rows[5] = {5'b01001, 3'h4, 8'hC3, 1'b0, 3'h4};
    rows[6] = {5'b01000, 3'h6, 8'h00, 1'b0, 3'h6};
    repeat (19) @(posedge clk);
    #1 `CHK("rst_oe", 3'b000, {host_data_bus_oe, dma_req_oe, irq_oe})
    @(posedge clk) #1 rst_n = 1;
    foreach (rows[i]) access(rows[i]);
    lv(7'b0101000); `CHK("term", 1'b1, core_term_count)
    lv(7'b0001000); `CHK("term", 1'b0, core_term_count)
    lv(7'b0111000); `CHK("term", 1'b0, core_term_count)
    lv(7'b1000000); `CHK("term", 1'b1, core_term_count)
    lv(7'b1001000); `CHK("term", 1'b0, core_term_count)
    lv(7'b0010010); `CHK("req_oe", 1'b0, dma_req_oe)
    lv(7'b0110010); `CHK("req", 2'b11, {dma_req_oe, dma_req_out})
    lv(7'b1011010); `CHK("req", 2'b11, {dma_req_oe, dma_req_out})
    lv(7'b1011110); `CHK("req", 1'b0, dma_req_out)
    `CHK("irq_pin", 1'b0, irq_pin)
    lv(7'b0110001); `CHK("irq", 2'b11, {irq_oe, irq_out})
    lv(7'b0010001); `CHK("irq_oe", 1'b0, irq_oe)
    lv(7'b1011001); `CHK("irq_pin", 1'b0, irq_pin)
    lv(7'b1011000); `CHK("irq_pin", 1'b1, irq_pin)
    rst_n = 0;
    lv(7'b1011001); `CHK("rst_oe", 2'b00, {dma_req_oe, irq_oe})
    wrap_up();
  end
endmodule : tb_top
